// [pkg/bsl_pkg.sv]
// boot stream loader constants: header codes, address windows, sizes
// assumes a 32-bit word stream and a 32-bit byte-addressed memory space
package bsl_pkg;

  localparam logic [31:0] HDR_HALF_SPEED = 32'h0000_3779;
  localparam logic [31:0] HDR_FULL_SPEED = 32'h0000_377D;
  localparam logic [2:0]  HDR_WORDS      = 3'h6;
  localparam logic [2:0]  HDR_START_IDX  = 3'h5;
  localparam logic [31:0] ADDR_STEP      = 32'h0000_0004;

  localparam logic [31:0] SRAM_LO  = 32'h0040_0000;
  localparam logic [31:0] SRAM_HI  = 32'h0047_FFFF;
  localparam logic [31:0] FLASH_LO = 32'h0140_0000;
  localparam logic [31:0] FLASH_HI = 32'h015F_FFFF;
  localparam logic [31:0] DRAM_LO  = 32'h0200_0000;
  localparam logic [31:0] DRAM_HI  = 32'h02FF_FFFF;

  typedef enum logic [2:0] {
    BSL_HDR  = 3'b000,
    BSL_LEN  = 3'b001,
    BSL_DEST = 3'b011,
    BSL_DATA = 3'b010,
    BSL_DONE = 3'b110,
    BSL_ERR  = 3'b111
  } bsl_state_e;

endpackage

// [hw/bsl_loader.sv]
// boot stream loader: header check, load-block parsing, external memory writes
// assumes host words arrive on the same clock with valid/ready; memory write
// port accepts a word whenever o_mem_we is high
//
// Contract
// - header word 1 of 0x00003779 selects and latches half-speed sram.
// - header word 1 of 0x0000377D selects full-speed sram.
// - six-word header; words 2,3,4,6 zero; word 5 is the start address, stored.
// - each block opens with its length in bytes, four times its data words.
// - block word 2 is the destination, which must lie in external memory.
// - exactly the indicated number of data words are written in order.
// - any number of blocks, including none, are processed in turn.
// - a zero length word ends the image and stops block reading.
// - 00400000 to 0047FFFF decodes as the sram region.
// - 02000000 to 02FFFFFF decodes as the dram region.
// - 01400000 to 015FFFFF decodes as flash, not a data destination.
// - half speed runs the sram at half the core clock.
`timescale 1ns/100ps

module bsl_loader
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  // host word stream
  input  wire logic [31:0] i_word,
  input  wire logic        i_word_valid,
  output logic             o_word_ready,
  // external memory write port
  output logic             o_mem_we,
  output logic [31:0]      o_mem_addr,
  output logic [31:0]      o_mem_data,
  output logic             o_sram_space_select,
  output logic             o_flash_space_select,
  output logic             o_dram_space_select,
  // memory clocking and hand-over
  output logic             o_sram_half_speed,
  output logic             o_sram_clk_en,
  output logic             o_done,
  output logic             o_error,
  output logic [31:0]      o_start_addr
);

  bsl_pkg::bsl_state_e state_q;
  logic [2:0]          hdr_cnt_q;
  logic [29:0]         words_left_q;
  logic [31:0]         addr_q;
  logic                take;
  logic                dest_sram;
  logic                dest_dram;
  logic                dest_flash;
  logic                hdr_ok;

  // ready while parsing from the first edge after reset; the stream stalls in reset and after done or error
  assign take = i_word_valid && o_word_ready;

  // region decode of the incoming destination word
  assign dest_sram  = (i_word >= bsl_pkg::SRAM_LO) && (i_word <= bsl_pkg::SRAM_HI);
  assign dest_dram  = (i_word >= bsl_pkg::DRAM_LO) && (i_word <= bsl_pkg::DRAM_HI);
  assign dest_flash = (i_word >= bsl_pkg::FLASH_LO) && (i_word <= bsl_pkg::FLASH_HI);

  always_comb
  begin
    if (hdr_cnt_q == 3'h0)
    begin
      hdr_ok = (i_word == bsl_pkg::HDR_HALF_SPEED) ||
               (i_word == bsl_pkg::HDR_FULL_SPEED);
    end
    else if (hdr_cnt_q == (bsl_pkg::HDR_START_IDX - 3'h1))
    begin
      hdr_ok = 1'b1;
    end
    else
    begin
      hdr_ok = (i_word == 32'h0000_0000);
    end
  end

  // parser state
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state_q   <= bsl_pkg::BSL_HDR;
      hdr_cnt_q <= 3'h0;
    end
    else if (take)
    begin
      case (state_q)
        bsl_pkg::BSL_HDR:
        begin
          if (!hdr_ok)
          begin
            state_q <= bsl_pkg::BSL_ERR;
          end
          else if (hdr_cnt_q == (bsl_pkg::HDR_WORDS - 3'h1))
          begin
            state_q <= bsl_pkg::BSL_LEN;
          end
          hdr_cnt_q <= hdr_cnt_q + 3'h1;
        end
        bsl_pkg::BSL_LEN:
        begin
          // length in bytes; a zero word terminates, low bits assumed zero
          if (i_word[31:2] == 30'h0000_0000)
          begin
            state_q <= bsl_pkg::BSL_DONE;
          end
          else
          begin
            state_q <= bsl_pkg::BSL_DEST;
          end
        end
        bsl_pkg::BSL_DEST:
        begin
          if (dest_sram || dest_dram)
          begin
            state_q <= bsl_pkg::BSL_DATA;
          end
          else
          begin
            state_q <= bsl_pkg::BSL_ERR;
          end
        end
        bsl_pkg::BSL_DATA:
        begin
          if (words_left_q == 30'h0000_0001)
          begin
            state_q <= bsl_pkg::BSL_LEN;
          end
        end
        default:
        begin
          state_q <= state_q;
        end
      endcase
    end
  end

  // block word count
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      words_left_q <= 30'h0000_0000;
    end
    else if (take && state_q == bsl_pkg::BSL_LEN)
    begin
      words_left_q <= i_word[31:2];
    end
    else if (take && state_q == bsl_pkg::BSL_DATA)
    begin
      words_left_q <= words_left_q - 30'h0000_0001;
    end
  end

  // write address
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      addr_q <= 32'h0000_0000;
    end
    else if (take && state_q == bsl_pkg::BSL_DEST)
    begin
      addr_q <= i_word;
    end
    else if (take && state_q == bsl_pkg::BSL_DATA)
    begin
      addr_q <= addr_q + bsl_pkg::ADDR_STEP;
    end
  end

  // memory write port, registered one cycle after the data word is taken
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_mem_we             <= 1'b0;
      o_mem_addr           <= 32'h0000_0000;
      o_mem_data           <= 32'h0000_0000;
      o_sram_space_select  <= 1'b0;
      o_flash_space_select <= 1'b0;
      o_dram_space_select  <= 1'b0;
    end
    else
    begin
      o_mem_we   <= take && (state_q == bsl_pkg::BSL_DATA);
      o_mem_addr <= addr_q;
      o_mem_data <= i_word;
      // flash never selected here: flash is not a legal destination
      o_flash_space_select <= 1'b0;
      // full window compare: a block that runs off its region selects neither
      o_sram_space_select  <= take && (state_q == bsl_pkg::BSL_DATA) &&
                              (addr_q >= bsl_pkg::SRAM_LO) &&
                              (addr_q <= bsl_pkg::SRAM_HI);
      o_dram_space_select  <= take && (state_q == bsl_pkg::BSL_DATA) &&
                              (addr_q >= bsl_pkg::DRAM_LO) &&
                              (addr_q <= bsl_pkg::DRAM_HI);
    end
  end

  // header results: speed choice and start address
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_sram_half_speed <= 1'b0;
      o_start_addr      <= 32'h0000_0000;
    end
    else if (take && state_q == bsl_pkg::BSL_HDR)
    begin
      if (hdr_cnt_q == 3'h0)
      begin
        o_sram_half_speed <= (i_word == bsl_pkg::HDR_HALF_SPEED);
      end
      if (hdr_cnt_q == (bsl_pkg::HDR_START_IDX - 3'h1))
      begin
        o_start_addr <= i_word;
      end
    end
  end

  // sram clock enable: every cycle at full speed, every other at half
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_sram_clk_en <= 1'b1;
    end
    else if (o_sram_half_speed)
    begin
      o_sram_clk_en <= !o_sram_clk_en;
    end
    else
    begin
      o_sram_clk_en <= 1'b1;
    end
  end

  // status and flow control
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_done       <= 1'b0;
      o_error      <= 1'b0;
      o_word_ready <= 1'b0;
    end
    else
    begin
      o_done  <= (state_q == bsl_pkg::BSL_DONE);
      o_error <= (state_q == bsl_pkg::BSL_ERR);
      // ready falls on the same edge that enters done or error; stops the stream once parsing ends
      o_word_ready <= (state_q != bsl_pkg::BSL_DONE) &&
                      (state_q != bsl_pkg::BSL_ERR) &&
                      !(take && state_q == bsl_pkg::BSL_LEN && i_word[31:2] == 30'h0) &&
                      !(take && state_q == bsl_pkg::BSL_HDR && !hdr_ok) &&
                      !(take && state_q == bsl_pkg::BSL_DEST && !(dest_sram || dest_dram));
    end
  end

  // checks
  a_write_follows_data: assert property (@(posedge i_clk) disable iff (!i_nrst)
    take && state_q == bsl_pkg::BSL_DATA |=> o_mem_we && o_mem_data == $past(i_word))
    else $error("data word not written");
  a_addr_step: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_mem_we ##1 o_mem_we |-> o_mem_addr == $past(o_mem_addr) + bsl_pkg::ADDR_STEP)
    else $error("write address did not step by four");
  a_zero_len_ends: assert property (@(posedge i_clk) disable iff (!i_nrst)
    take && state_q == bsl_pkg::BSL_LEN && i_word == 32'h0000_0000 |=> ##1 o_done)
    else $error("terminator did not end the stream");
  a_done_stops: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_done |-> !o_word_ready && !o_mem_we)
    else $error("activity after done");
  a_bad_hdr_err: assert property (@(posedge i_clk) disable iff (!i_nrst)
    take && state_q == bsl_pkg::BSL_HDR && hdr_cnt_q == 3'h0 &&
    i_word != bsl_pkg::HDR_HALF_SPEED && i_word != bsl_pkg::HDR_FULL_SPEED |=> ##1 o_error)
    else $error("bad header not flagged");
  a_bad_dest_err: assert property (@(posedge i_clk) disable iff (!i_nrst)
    take && state_q == bsl_pkg::BSL_DEST && dest_flash |=> ##1 o_error)
    else $error("flash destination not rejected");
  a_half_speed: assert property (@(posedge i_clk) disable iff (!i_nrst)
    take && state_q == bsl_pkg::BSL_HDR && hdr_cnt_q == 3'h0 &&
    i_word == bsl_pkg::HDR_HALF_SPEED |=> o_sram_half_speed)
    else $error("half speed not latched");
  a_half_clk: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_sram_half_speed && $past(o_sram_half_speed) |->
    o_sram_clk_en != $past(o_sram_clk_en))
    else $error("half-speed enable not alternating");
  a_start_kept: assert property (@(posedge i_clk) disable iff (!i_nrst)
    take && state_q == bsl_pkg::BSL_HDR && hdr_cnt_q == (bsl_pkg::HDR_START_IDX - 3'h1)
    |=> o_start_addr == $past(i_word))
    else $error("start address not stored");
  a_region_ok: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_mem_we |-> o_sram_space_select != o_dram_space_select)
    else $error("write without one region selected");

endmodule

// [test/bsl_host_model.sv]
// host transmitter model: sends boot image words on a valid/ready stream
// assumes the loader samples valid and ready on the rising clock edge
`timescale 1ns/100ps

module bsl_host_model
(
  // clock
  input  wire logic        i_clk,
  // word stream
  input  wire logic        i_ready,
  output logic [31:0]      o_word,
  output logic             o_valid
);
  int gap;
  int timeouts;

  initial
  begin
    o_word   = 32'h0000_0000;
    o_valid  = 1'b0;
    gap      = 0;
    timeouts = 0;
  end

  // released line shows the inverse of its current value; a second idle in a row brings back the stale copy
  task automatic idle;
    #1 o_valid = 1'b0;
    o_word = ~o_word;
  endtask

  // call just after a rising edge; returns at the edge that took the word
  task automatic send(input logic [31:0] w);
    int n;
    n = 0;
    repeat (gap)
    begin
      idle();
      @(posedge i_clk);
    end
    #1 o_valid = 1'b1;
    o_word = w;
    do
    begin
      @(posedge i_clk);
      n++;
    end
    while (i_ready !== 1'b1 && n < 50);
    if (n >= 50)
      timeouts++;
  endtask
endmodule

// [test/tb_top.sv]
// boot stream loader bench: whole images, slow host, refused images
// assumes a host model drives the stream and memory accepts every write
`timescale 1ns/100ps

module tb_top;
  logic        i_clk;
  logic        i_nrst;
  logic [31:0] i_word;
  logic        i_word_valid;
  logic        o_word_ready;
  logic        o_mem_we;
  logic [31:0] o_mem_addr;
  logic [31:0] o_mem_data;
  logic        o_sram_space_select;
  logic        o_flash_space_select;
  logic        o_dram_space_select;
  logic        o_sram_half_speed;
  logic        o_sram_clk_en;
  logic        o_done;
  logic        o_error;
  logic [31:0] o_start_addr;
  int          failures;
  int          checks_done;
  logic [31:0] wr_addr[$];
  logic [31:0] wr_data[$];
  logic [1:0]  wr_sel[$];

  initial i_clk = 1'b0;
  always #4 i_clk = ~i_clk;

  bsl_loader i_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_word(i_word),
    .i_word_valid(i_word_valid), .o_word_ready(o_word_ready), .o_mem_we(o_mem_we),
    .o_mem_addr(o_mem_addr), .o_mem_data(o_mem_data),
    .o_sram_space_select(o_sram_space_select), .o_flash_space_select(o_flash_space_select),
    .o_dram_space_select(o_dram_space_select), .o_sram_half_speed(o_sram_half_speed),
    .o_sram_clk_en(o_sram_clk_en), .o_done(o_done), .o_error(o_error),
    .o_start_addr(o_start_addr));

  bsl_host_model i_host (.i_clk(i_clk), .i_ready(o_word_ready), .o_word(i_word),
    .o_valid(i_word_valid));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    failures += i_host.timeouts;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // sampled mid-cycle so the write port is looked at while it stands
  always @(negedge i_clk)
  begin
    if (o_mem_we === 1'b1)
    begin
      wr_addr.push_back(o_mem_addr);
      wr_data.push_back(o_mem_data);
      wr_sel.push_back({o_sram_space_select, o_dram_space_select});
      check(32'(o_flash_space_select), 32'h0000_0000);
    end
  end

  task automatic do_reset;
    @(posedge i_clk);
    #1 i_nrst = 1'b0;
    wr_addr.delete();
    wr_data.delete();
    wr_sel.delete();
    repeat (20) @(posedge i_clk);
    check(32'(o_done), 32'h0000_0000);
    check(32'(o_error), 32'h0000_0000);
    check(32'(o_sram_clk_en), 32'h0000_0001);
    #1 i_nrst = 1'b1;
    @(posedge i_clk);
  endtask

  // block data is whole words, so byte lengths are multiples of four
  task automatic send_list(input logic [31:0] q[$]);
    foreach (q[k])
    begin
      i_host.send(q[k]);
      if (i_host.timeouts != 0)
        finish_test();
    end
    i_host.idle();
  endtask

  task automatic wait_end;
    int n;
    n = 0;
    while (o_done !== 1'b1 && o_error !== 1'b1)
    begin
      @(posedge i_clk);
      n++;
      if (n > 40)
      begin
        failures++;
        finish_test();
      end
    end
    repeat (2) @(posedge i_clk);
    #1;
  endtask

  task automatic s_full;
    do_reset();
    send_list({32'h0000_377D, 32'h0, 32'h0, 32'h0, 32'h0040_0100, 32'h0, 32'h0000_000C,
      32'h0040_0000, 32'hD000_0000, 32'hD000_0001, 32'hD000_0002, 32'h0000_0008,
      32'h02FF_FFF8, 32'hD000_0003, 32'hD000_0004, 32'h0});
    wait_end();
    check(32'(o_done), 32'h0000_0001);
    check(32'(o_error), 32'h0000_0000);
    check(32'(o_word_ready), 32'h0000_0000);
    check(o_start_addr, 32'h0040_0100);
    check(32'(o_sram_half_speed), 32'h0000_0000);
    check(32'(o_sram_clk_en), 32'h0000_0001);
    check(32'(wr_addr.size()), 32'h0000_0005);
    for (int k = 0; k < 5; k++)
    begin
      check(wr_addr[k], (k < 3) ? 32'h0040_0000 + 4 * k : 32'h02FF_FFEC + 4 * k);
      check(wr_data[k], 32'hD000_0000 + k);
      check(32'(wr_sel[k]), (k < 3) ? 32'h0000_0002 : 32'h0000_0001);
    end
  endtask

  task automatic s_half;
    logic en;
    do_reset();
    i_host.gap = 2;
    send_list({32'h0000_3779, 32'h0, 32'h0, 32'h0, 32'h0200_0040, 32'h0, 32'h0});
    i_host.gap = 0;
    wait_end();
    check(32'(o_done), 32'h0000_0001);
    check(32'(o_sram_half_speed), 32'h0000_0001);
    check(o_start_addr, 32'h0200_0040);
    check(32'(wr_addr.size()), 32'h0000_0000);
    en = o_sram_clk_en;
    @(posedge i_clk);
    #1;
    check(32'(en ^ o_sram_clk_en), 32'h0000_0001);
  endtask

  task automatic bad_run(input logic [31:0] q[$]);
    do_reset();
    send_list(q);
    wait_end();
    check(32'(o_error), 32'h0000_0001);
    check(32'(o_done), 32'h0000_0000);
    check(32'(o_word_ready), 32'h0000_0000);
    check(32'(wr_addr.size()), 32'h0000_0000);
  endtask

  task automatic s_bad;
    bad_run({32'h0000_3778});
    bad_run({32'h0000_377D, 32'h0, 32'h0000_0001});
    bad_run({32'h0000_377D, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h4, 32'h0140_0000});
    bad_run({32'h0000_377D, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h4, 32'h0048_0000});
  endtask

  initial
  begin
    failures = 0;
    checks_done = 0;
    i_nrst = 1'b0;
    s_full();
    s_half();
    s_bad();
    finish_test();
  end
endmodule
